// ===== imu_defs.vh
// Contract
// - flag bit7 on sync lock loss, scaled mode
// - flag bit6 when flash crc test mismatches
// - flag bit5 when sensor self test fails
// - bit4 and halt below supply; resume after 250ms
// - flag bit3 when clocks not multiple of 16
// - flag bit2 when last flash update failed
// - flag bit1 on data path overrun; reset recovers
// - status read returns contents then clears flags
// - flags stay set until read clears them
// - persisting condition sets flag again after read
// - three axes, each its own register pair
// - 32-bit two's complement split high/low words
// - high word scale 160, 40, 10 by variant
// - high word full scale 0x4e20 / 0xb1e0
// - 32-bit full scale 0x4e200000 / 0xb1e00000
// - high words read as two's complement, zero 0
`ifndef IMU_DEFS_VH
`define IMU_DEFS_VH

// register addresses (7-bit, even byte of each word)
`define ADDR_DIAG 7'h02
`define ADDR_X_LOW 7'h04
`define ADDR_X_HIGH 7'h06
`define ADDR_Y_LOW 7'h08
`define ADDR_Y_HIGH 7'h0a
`define ADDR_Z_LOW 7'h0c
`define ADDR_Z_HIGH 7'h0e
`define ADDR_MISC 7'h60
`define ADDR_GCMD 7'h68

// diagnostic flag positions
`define FLAG_CLOCK 7
`define FLAG_FLASH_TEST 6
`define FLAG_SENSOR 5
`define FLAG_STANDBY 4
`define FLAG_SPI 3
`define FLAG_UPDATE 2
`define FLAG_OVERRUN 1
`define FLAG_MASK 16'h00fe
`define DIAG_RESET 16'h0000

// global command bits
`define GCMD_SELF_TEST 2
`define GCMD_FLASH_UPDATE 3
`define GCMD_FLASH_TEST 4
`define GCMD_SOFT_RESET 7

// misc io control: sync mode field and reset value
`define MISC_RESET 16'h00c1
`define SYNC_MODE_HI 4
`define SYNC_MODE_LO 2
`define SYNC_SCALED 3'h2

// serial word layout
`define WORD_BITS 16
`define BITCNT_W 4
`define WR_BIT 15
`define ADDR_HI 14
`define ADDR_LO 8

// range variants: shift from finest scale
`define VAR_SMALL 2'h0
`define VAR_MID 2'h1
`define VAR_LARGE 2'h2
`define SHIFT_MID 2
`define SHIFT_LARGE 4
`define FULL_POS 32'h4e200000
`define FULL_NEG 32'hb1e00000

// supply recovery time
`define RECOVER_MS 250
`define CLK_KHZ 50000
`define RECOVER_W 24

`endif

// ===== gyro_rate_format.v
`timescale 1ns/1ps
`include "imu_defs.vh"
// turns a raw rate at the finest scale into the variant's output word
module gyro_rate_format (
    // raw rate, units of 1/(160*65536) deg/s
    input wire [31:0] i_raw,
    input wire [1:0] i_variant,
    // formatted 32-bit word, high word first in bits 31:16
    output reg [31:0] o_word
);
    reg signed [31:0] scaled; // rate after variant scaling

    // coarser variants drop resolution by arithmetic shift
    always @*
    begin
        case (i_variant)
            `VAR_MID: scaled = $signed(i_raw) >>> `SHIFT_MID;
            `VAR_LARGE: scaled = $signed(i_raw) >>> `SHIFT_LARGE;
            default: scaled = $signed(i_raw);
        endcase
        // clamp so full scale reads exactly as specified
        if (scaled > $signed(`FULL_POS))
        begin
            o_word = `FULL_POS;
        end
        else if (scaled < $signed(`FULL_NEG))
        begin
            o_word = `FULL_NEG;
        end
        else
        begin
            o_word = scaled;
        end
    end
endmodule

// ===== imu_diag_gyro.v
`timescale 1ns/1ps
`include "imu_defs.vh"
// serial register slave with diagnostic flags and gyro output words
module imu_diag_gyro #(
    parameter RECOVER_CYC = `RECOVER_MS * `CLK_KHZ
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // serial port, mode 3, 16-bit words
    input wire i_sclk,
    input wire i_cs_n,
    input wire i_mosi,
    output reg o_miso,
    output reg o_miso_oe,
    // error sources
    input wire i_sync_unlocked,
    input wire i_supply_low,
    input wire i_overrun,
    input wire i_self_test_done,
    input wire i_self_test_fail,
    input wire i_flash_test_done,
    input wire i_crc_mismatch,
    input wire i_flash_update_done,
    input wire i_flash_update_fail,
    // rate samples from the sensor path
    input wire [1:0] i_range_variant,
    input wire i_rate_valid,
    input wire [31:0] i_rate_x,
    input wire [31:0] i_rate_y,
    input wire [31:0] i_rate_z,
    // command strobes and state
    output reg o_self_test_start,
    output reg o_flash_test_start,
    output reg o_flash_update_start,
    output reg o_soft_reset,
    output reg o_data_halt,
    output reg o_reinit
);
    // synchronisers for pins
    reg sclk_a_q, sclk_b_q, sclk_c_q;
    reg cs_a_q, cs_b_q, cs_c_q;
    reg mosi_a_q, mosi_b_q;
    reg low_a_q, low_b_q;
    // serial state
    reg [`BITCNT_W-1:0] bitcnt_q; // bits within the current word
    reg [15:0] rx_q; // incoming word
    reg [15:0] tx_q; // outgoing word
    // registers
    reg [15:0] diag_q; // sticky flags
    reg [15:0] misc_q; // misc io control
    reg [31:0] x_q, y_q, z_q; // formatted rate words
    // latched test results, held until the next test
    reg st_fail_q, crc_bad_q, upd_fail_q;
    reg [`RECOVER_W-1:0] rec_q; // supply recovery counter
    wire [31:0] x_fmt, y_fmt, z_fmt;
    wire sclk_rise = sclk_b_q & ~sclk_c_q;
    wire sclk_fall = ~sclk_b_q & sclk_c_q;
    wire cs_end = cs_b_q & ~cs_c_q;
    wire active = ~cs_b_q;
    wire [15:0] word_in = {rx_q[14:0], mosi_b_q};
    wire word_done = active & sclk_rise & (bitcnt_q == `WORD_BITS - 1);
    wire is_wr = word_in[`WR_BIT];
    wire [6:0] waddr = word_in[`ADDR_HI:`ADDR_LO];
    wire diag_rd = word_done & ~is_wr & (rd_key(waddr) == `ADDR_DIAG);
    reg [15:0] events; // this cycle's error conditions
    reg [15:0] diag_d;

    // word address decode, byte bit ignored
    function [6:0] rd_key;
        input [6:0] a;
        begin
            rd_key = {a[6:1], 1'b0};
        end
    endfunction

    // read data mux for a word address
    function [15:0] rd_data;
        input [6:0] a;
        begin
            case (rd_key(a))
                `ADDR_DIAG: rd_data = diag_q & `FLAG_MASK;
                `ADDR_X_LOW: rd_data = x_q[15:0];
                `ADDR_X_HIGH: rd_data = x_q[31:16];
                `ADDR_Y_LOW: rd_data = y_q[15:0];
                `ADDR_Y_HIGH: rd_data = y_q[31:16];
                `ADDR_Z_LOW: rd_data = z_q[15:0];
                `ADDR_Z_HIGH: rd_data = z_q[31:16];
                `ADDR_MISC: rd_data = misc_q;
                default: rd_data = 16'h0000; // unmapped reads zero
            endcase
        end
    endfunction

    // three formatters, one per axis
    gyro_rate_format u_fmt_x (.i_raw(i_rate_x), .i_variant(i_range_variant), .o_word(x_fmt));
    gyro_rate_format u_fmt_y (.i_raw(i_rate_y), .i_variant(i_range_variant), .o_word(y_fmt));
    gyro_rate_format u_fmt_z (.i_raw(i_rate_z), .i_variant(i_range_variant), .o_word(z_fmt));

    // two flops per pin before any logic looks at it
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sclk_a_q <= 1'b1;
            sclk_b_q <= 1'b1;
            sclk_c_q <= 1'b1;
            cs_a_q <= 1'b1;
            cs_b_q <= 1'b1;
            cs_c_q <= 1'b1;
            mosi_a_q <= 1'b0;
            mosi_b_q <= 1'b0;
            low_a_q <= 1'b0;
            low_b_q <= 1'b0;
        end
        else
        begin
            sclk_a_q <= i_sclk;
            sclk_b_q <= sclk_a_q;
            sclk_c_q <= sclk_b_q;
            cs_a_q <= i_cs_n;
            cs_b_q <= cs_a_q;
            cs_c_q <= cs_b_q;
            mosi_a_q <= i_mosi;
            mosi_b_q <= mosi_a_q;
            low_a_q <= i_supply_low;
            low_b_q <= low_a_q;
        end
    end

    // gather error conditions; level sources keep re-raising flags
    always @*
    begin
        events = 16'h0000;
        events[`FLAG_CLOCK] = i_sync_unlocked &
            (misc_q[`SYNC_MODE_HI:`SYNC_MODE_LO] == `SYNC_SCALED);
        events[`FLAG_FLASH_TEST] = crc_bad_q;
        events[`FLAG_SENSOR] = st_fail_q;
        events[`FLAG_STANDBY] = low_b_q;
        events[`FLAG_SPI] = cs_end & (bitcnt_q != {`BITCNT_W{1'b0}});
        events[`FLAG_UPDATE] = upd_fail_q;
        events[`FLAG_OVERRUN] = i_overrun;
        // clear on read, but a new event wins over the clear
        diag_d = ((diag_rd ? 16'h0000 : diag_q) | events) & `FLAG_MASK;
    end

    // serial shifting, register writes and read loading
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bitcnt_q <= {`BITCNT_W{1'b0}};
            rx_q <= 16'h0000;
            tx_q <= 16'h0000;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
            misc_q <= `MISC_RESET;
            o_self_test_start <= 1'b0;
            o_flash_test_start <= 1'b0;
            o_flash_update_start <= 1'b0;
            o_soft_reset <= 1'b0;
        end
        else
        begin
            o_self_test_start <= 1'b0;
            o_flash_test_start <= 1'b0;
            o_flash_update_start <= 1'b0;
            o_soft_reset <= 1'b0;
            o_miso_oe <= active;
            if (!active)
            begin
                // frame over: count restarts, reply stays for next frame
                bitcnt_q <= {`BITCNT_W{1'b0}};
            end
            else
            begin
                if (sclk_fall)
                begin
                    // mode 3 drives on the falling edge
                    o_miso <= tx_q[15];
                    tx_q <= {tx_q[14:0], 1'b0};
                end
                if (sclk_rise)
                begin
                    rx_q <= word_in;
                    bitcnt_q <= bitcnt_q + 1'b1;
                end
                if (word_done)
                begin
                    if (is_wr)
                    begin
                        tx_q <= 16'h0000;
                        if (rd_key(waddr) == `ADDR_MISC)
                        begin
                            // byte lane picked by address bit 0
                            if (waddr[0])
                                misc_q[15:8] <= word_in[7:0];
                            else
                                misc_q[7:0] <= word_in[7:0];
                        end
                        else if (waddr == `ADDR_GCMD)
                        begin
                            o_self_test_start <= word_in[`GCMD_SELF_TEST];
                            o_flash_update_start <= word_in[`GCMD_FLASH_UPDATE];
                            o_flash_test_start <= word_in[`GCMD_FLASH_TEST];
                            o_soft_reset <= word_in[`GCMD_SOFT_RESET];
                        end
                    end
                    else
                    begin
                        // reply shifts out in the following word
                        tx_q <= rd_data(waddr);
                    end
                end
            end
        end
    end

    // sticky flags, test results and standby handling
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            diag_q <= `DIAG_RESET;
            st_fail_q <= 1'b0;
            crc_bad_q <= 1'b0;
            upd_fail_q <= 1'b0;
            rec_q <= {`RECOVER_W{1'b0}};
            o_data_halt <= 1'b0;
            o_reinit <= 1'b0;
        end
        else
        begin
            diag_q <= diag_d;
            o_reinit <= 1'b0;
            // results hold until the same test runs again
            if (i_self_test_done)
                st_fail_q <= i_self_test_fail;
            if (i_flash_test_done)
                crc_bad_q <= i_crc_mismatch;
            if (i_flash_update_done)
                upd_fail_q <= i_flash_update_fail;
            if (low_b_q)
            begin
                // any dip restarts the full recovery wait
                o_data_halt <= 1'b1;
                rec_q <= {`RECOVER_W{1'b0}};
            end
            else if (o_data_halt)
            begin
                if (rec_q == RECOVER_CYC[`RECOVER_W-1:0] - 1'b1)
                begin
                    o_data_halt <= 1'b0;
                    o_reinit <= 1'b1;
                    rec_q <= {`RECOVER_W{1'b0}};
                end
                else
                begin
                    rec_q <= rec_q + 1'b1;
                end
            end
        end
    end

    // rate words update together so high and low stay paired
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            x_q <= 32'h00000000;
            y_q <= 32'h00000000;
            z_q <= 32'h00000000;
        end
        else if (i_rate_valid && !o_data_halt)
        begin
            x_q <= x_fmt;
            y_q <= y_fmt;
            z_q <= z_fmt;
        end
    end
endmodule

// ===== imu_diag_checker.sv
`timescale 1ns/1ps
// standby timing and strobe width checks
module imu_diag_checker #(
    parameter RECOVER_CYC = 20
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // watched ports
    input wire i_cs_n,
    input wire i_supply_low,
    input wire o_miso_oe,
    input wire o_self_test_start,
    input wire o_flash_test_start,
    input wire o_flash_update_start,
    input wire o_soft_reset,
    input wire o_data_halt,
    input wire o_reinit
);
    // cycles since supply was last low
    logic [31:0] good_q;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    // saturates so a long run never wraps
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            good_q <= 32'h0;
        else if (i_supply_low)
            good_q <= 32'h0;
        else if (~&good_q)
            good_q <= good_q + 32'h1;
    end
    halt_on_low_a: assert property (i_supply_low [*5] |-> o_data_halt)
        else $error("no halt on low supply");
    resume_wait_a: assert property ($fell(o_data_halt) |-> good_q >= RECOVER_CYC)
        else $error("resumed too early");
    reinit_gap_a: assert property (o_reinit |-> !o_data_halt && good_q >= RECOVER_CYC)
        else $error("bad reinit");
    self_pulse_a: assert property (o_self_test_start |=> !o_self_test_start)
        else $error("self test strobe long");
    crc_pulse_a: assert property (o_flash_test_start |=> !o_flash_test_start)
        else $error("flash test strobe long");
    update_pulse_a: assert property (o_flash_update_start |=> !o_flash_update_start)
        else $error("update strobe long");
    soft_pulse_a: assert property (o_soft_reset |=> !o_soft_reset)
        else $error("soft reset strobe long");
    select_oe_a: assert property (!i_cs_n [*6] |-> o_miso_oe)
        else $error("reply not enabled");
    cover property ($rose(o_data_halt));
    cover property (o_reinit);
    cover property (o_soft_reset);
endmodule
bind imu_diag_gyro imu_diag_checker #(.RECOVER_CYC(RECOVER_CYC)) u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_supply_low(i_supply_low),
    .o_miso_oe(o_miso_oe), .o_self_test_start(o_self_test_start),
    .o_flash_test_start(o_flash_test_start), .o_flash_update_start(o_flash_update_start),
    .o_soft_reset(o_soft_reset), .o_data_halt(o_data_halt), .o_reinit(o_reinit)
);

// ===== spi_host_model.sv
`timescale 1ns/1ps
// serial host: mode 3, msb first, 160 ns clock
module spi_host_model (
    // frame request
    input wire i_go,
    input wire [5:0] i_nbits,
    input wire [31:0] i_tx,
    // serial pins
    output logic o_sclk = 1'b1,
    output logic o_cs_n = 1'b1,
    output logic o_mosi = 1'b0,
    input wire i_miso,
    // reply shift and end marker
    output logic [31:0] o_rx = 32'h0,
    output logic o_done = 1'b0
);
    // clock runs only inside a frame
    always @(posedge i_go)
    begin : frame
        int k;
        #7 o_cs_n = 1'b0;
        #80;
        for (k = 0; k < i_nbits; k++)
        begin
            o_sclk = 1'b0;
            o_mosi = i_tx[31 - k];
            #80 o_sclk = 1'b1;
            o_rx = {o_rx[30:0], i_miso};
            #80;
        end
        // released line flips, never a stale bit
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #320 o_done = 1'b1;
        #1 o_done = 1'b0;
    end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
// bench for flags and rate words
module tb;
    localparam int REC = 20;
    integer seed = 32'hd4c891f4;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic go = 1'b0;
    logic [5:0] nbits = 6'h0;
    logic [31:0] tx = 32'h0;
    wire sclk, cs_n, mosi, miso, miso_oe, done, halt;
    wire [31:0] rx;
    // strobes: self, crc, update, soft reset, reinit
    wire [4:0] stb;
    logic [6:0] ev = 7'h0;
    logic sync_ul = 1'b0;
    logic sup_low = 1'b0;
    logic vld = 1'b0;
    logic [1:0] rng = 2'h0;
    logic [31:0] rate [3];
    int fail_count = 0;
    int tests_run = 0;
    int ndone = 0;
    int sent = 0;
    int scnt [5] = '{0, 0, 0, 0, 0};
    logic [16:0] expq [$];
    imu_diag_gyro #(.RECOVER_CYC(REC)) u_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
        .o_miso(miso), .o_miso_oe(miso_oe), .i_sync_unlocked(sync_ul),
        .i_supply_low(sup_low), .i_overrun(ev[6]), .i_self_test_done(ev[5]),
        .i_self_test_fail(ev[4]), .i_flash_test_done(ev[3]), .i_crc_mismatch(ev[2]),
        .i_flash_update_done(ev[1]), .i_flash_update_fail(ev[0]), .i_range_variant(rng),
        .i_rate_valid(vld), .i_rate_x(rate[0]), .i_rate_y(rate[1]), .i_rate_z(rate[2]),
        .o_self_test_start(stb[0]), .o_flash_test_start(stb[1]),
        .o_flash_update_start(stb[2]), .o_soft_reset(stb[3]), .o_data_halt(halt),
        .o_reinit(stb[4])
    );
    spi_host_model u_host (
        .i_go(go), .i_nbits(nbits), .i_tx(tx), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_mosi(mosi), .i_miso(miso), .o_rx(rx), .o_done(done)
    );
    initial forever #10 i_mclk = ~i_mclk;
    // tally one-cycle strobes
    always @(posedge i_mclk)
        for (int j = 0; j < 5; j++)
            scnt[j] += stb[j];
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // oldest note against each finished frame
    always @(posedge done)
    begin : mon
        logic [16:0] e;
        ndone++;
        e = expq.pop_front();
        if (e[16])
            cmp(rx[15:0], e[15:0]);
    end
    // one frame, waits for its end with a bound
    task automatic frame(input int n, input logic [31:0] t, input logic [16:0] e);
        expq.push_back(e);
        sent++;
        nbits <= n[5:0];
        tx <= t;
        go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
        for (int k = 0; k < 4000 && ndone != sent; k++)
            @(posedge i_mclk);
    endtask
    // read word then a dummy word that carries the reply
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        frame(32, {1'b0, a, 24'h0}, {1'b1, e});
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        frame(16, {1'b1, a, d, 16'h0}, 17'h0);
    endtask
    task automatic pulse(input logic [6:0] m);
        ev <= m;
        @(posedge i_mclk);
        ev <= 7'h0;
    endtask
    // shift per range, then clamp to full scale
    function automatic logic [31:0] fmt(input logic signed [31:0] r, input int v);
        logic signed [31:0] s;
        s = (v == 2) ? r >>> 4 : (v == 1) ? r >>> 2 : r;
        if (s > 32'sh4e200000)
            s = 32'sh4e200000;
        if (s < 32'shb1e00000)
            s = 32'shb1e00000;
        return s;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge i_mclk);
        fail_count++;
        final_report();
    end
    initial
    begin : main
        logic [31:0] e;
        rate = '{32'h0, 32'h0, 32'h0};
        repeat (10) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_mclk);
        rd(7'h02, 16'h0000);
        wr(7'h68, 8'h9c);
        for (int j = 0; j < 4; j++)
            cmp(16'(scnt[j]), 16'h0001);
        // unlock ignored until scaled sync mode
        sync_ul <= 1'b1;
        rd(7'h02, 16'h0000);
        wr(7'h60, 8'hc9);
        sync_ul <= 1'b0;
        rd(7'h02, 16'h0080);
        rd(7'h02, 16'h0000);
        pulse(7'h7f);
        rd(7'h02, 16'h0066);
        pulse(7'h2a);
        rd(7'h02, 16'h0064);
        rd(7'h02, 16'h0000);
        // overrun lands on the very cycle the read word completes:
        // snapshot misses it, so it must survive the clear
        fork
            rd(7'h02, 16'h0000);
            begin
                repeat (130) @(posedge i_mclk);
                pulse(7'h40);
            end
        join
        rd(7'h02, 16'h0002);
        frame(8, 32'h0, 17'h0);
        rd(7'h02, 16'h0008);
        rd(7'h02, 16'h0000);
        sup_low <= 1'b1;
        repeat (10) @(posedge i_mclk);
        cmp({15'h0, halt}, 16'h0001);
        rd(7'h02, 16'h0010);
        rd(7'h02, 16'h0010);
        // a sample offered while halted must not reach the words
        rate[0] <= 32'h12345678;
        vld <= 1'b1;
        @(posedge i_mclk);
        vld <= 1'b0;
        rd(7'h06, 16'h0000);
        sup_low <= 1'b0;
        repeat (REC + 40) @(posedge i_mclk);
        cmp({15'h0, halt}, 16'h0000);
        cmp(16'(scnt[4]), 16'h0001);
        rd(7'h02, 16'h0010);
        for (int v = 0; v < 3; v++)
        begin
            rng <= v[1:0];
            rate[0] <= (v == 1) ? 32'h80000000 : 32'h7fffffff;
            // finest range drives y to the negative clamp
            rate[1] <= (v == 0) ? 32'h80000000 : $random(seed);
            rate[2] <= $random(seed);
            vld <= 1'b1;
            @(posedge i_mclk);
            vld <= 1'b0;
            @(posedge i_mclk);
            for (int a = 0; a < 3; a++)
            begin
                e = fmt(rate[a], v);
                rd(7'(6 + 4 * a), e[31:16]);
                rd(7'(4 + 4 * a), e[15:0]);
            end
        end
        final_report();
    end
endmodule
